// File: logic/sar_adc_map.vh
// What this block does
// - Serial result output changes only after a rising serial clock edge or a convert-start fall.
// - Convert-start falling edge begins conversion and puts track-hold into hold.
// - Track-hold returns to tracking on the fourteenth rising serial clock edge.
// - Track-hold is tracking straight after power-up.
// - First conversion after power-up initialises calibration; not needed after power-down.
// - Convert-start falling edge makes the serial output driven low.
// - Serial clock paces the approximation; each bit is output once decided.
// - Result MSB appears after the fourth rising edge, held until the fifth.
// - Frame is three zeros plus twelve bits; host gives sixteen rising edges.
// - Low convert-start at sixteenth falling edge releases output on next convert-start rise.
// - Convert-start raised after edge three, before fourteen, enters partial power-down.
// - Repeating that sequence in partial power-down enters full power-down, reference off.
// - Frame ends in one zero; straight binary unipolar, two's complement bipolar.
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH
`define RES_BITS 12
`define CNT_W 5
`define CNT_MAX 5'h1f
`define EDGE_PD_MIN 5'h03
`define EDGE_MSB 5'h04
`define EDGE_LSB 5'h0f
`define EDGE_TRACK 5'h0e
`define EDGE_LAST 5'h10
`define PWR_NORMAL 2'h0
`define PWR_PARTIAL 2'h1
`define PWR_FULL 2'h2
`define TRIAL_MSB 12'h800
`endif

// File: logic/sar_decider.v
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_map.vh"
module sar_decider
(
   input wire clk_sys,
   input wire rst,
   input wire sar_clear,
   input wire sar_step,
   input wire comp_high,
   output reg [11:0] trial_code_ff,
   output reg [11:0] result_ff
);
   reg [11:0] trial_mask_ff;
   reg [11:0] nxt_code;

   // Keep the decided bit, try the next lower one
   always @*
   begin
      nxt_code = (trial_code_ff & ~trial_mask_ff) | (comp_high ? trial_mask_ff : 12'h000)
         | (trial_mask_ff >> 1);
   end

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         trial_code_ff <= `TRIAL_MSB;
         trial_mask_ff <= 12'h000;
         result_ff <= 12'h000;
      end
      else if (sar_clear)
      begin
         trial_code_ff <= `TRIAL_MSB;
         trial_mask_ff <= `TRIAL_MSB;
      end
      else if (sar_step && (trial_mask_ff != 12'h000))
      begin
         trial_code_ff <= nxt_code;
         trial_mask_ff <= trial_mask_ff >> 1;
         if (trial_mask_ff == 12'h001)
         begin
            result_ff <= nxt_code;
         end
      end
   end
endmodule // sar_decider
`default_nettype wire

// File: logic/sar_adc_serial_conversion_port.v
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_map.vh"
module sar_adc_serial_conversion_port
(
   input wire clk_sys,
   input wire rst,
   input wire sclk,
   input wire convert_start_line,
   input wire comp_high,
   input wire bipolar_sel,
   output reg dout_ff,
   output reg dout_oe_ff,
   output reg tracking_ff,
   output reg converting_ff,
   output reg calib_done_ff,
   output reg ref_enable_ff,
   output reg [1:0] power_state_ff,
   output reg [11:0] result_word_ff,
   output reg result_valid_ff,
   output wire [11:0] dac_code
);
   reg sclk_prev_ff;
   reg cnv_prev_ff;
   reg [4:0] rise_cnt_ff;
   reg [4:0] fall_cnt_ff;
   reg release_pend_ff;
   reg sar_clear_ff;
   reg [4:0] nxt_rise_cnt;
   reg [1:0] nxt_power_state;
   wire sclk_rise;
   wire sclk_fall;
   wire cnv_fall;
   wire cnv_rise;
   wire data_edge;
   wire sar_step;
   wire [11:0] sar_result;

   // Saturating edge counter step
   function [4:0] count_up;
      input [4:0] cnt;
      begin
         count_up = (cnt == `CNT_MAX) ? cnt : cnt + 5'h01;
      end
   endfunction

   // True when count lies in [lo, hi)
   function in_window;
      input [4:0] cnt;
      input [4:0] lo;
      input [4:0] hi;
      begin
         in_window = (cnt >= lo) && (cnt < hi);
      end
   endfunction

   assign sclk_rise = sclk & ~sclk_prev_ff;
   assign sclk_fall = ~sclk & sclk_prev_ff;
   assign cnv_fall = ~convert_start_line & cnv_prev_ff;
   assign cnv_rise = convert_start_line & ~cnv_prev_ff;
   // A new conversion restarts counting; an edge in the same cycle is not counted
   assign data_edge = sclk_rise && !cnv_fall && converting_ff;

   always @*
   begin
      nxt_rise_cnt = count_up(rise_cnt_ff);
   end

   assign sar_step = data_edge && in_window(nxt_rise_cnt, `EDGE_MSB, `EDGE_LSB + 5'h01);

   sar_decider u_sar
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .sar_clear(sar_clear_ff),
      .sar_step(sar_step),
      .comp_high(comp_high),
      .trial_code_ff(dac_code),
      .result_ff(sar_result)
   );

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         sclk_prev_ff <= 1'b0;
         cnv_prev_ff <= 1'b1;
      end
      else
      begin
         sclk_prev_ff <= sclk;
         cnv_prev_ff <= convert_start_line;
      end
   end

   // Edge counters since the convert-start fall
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         rise_cnt_ff <= 5'h00;
         fall_cnt_ff <= 5'h00;
         converting_ff <= 1'b0;
         sar_clear_ff <= 1'b0;
      end
      else
      begin
         sar_clear_ff <= cnv_fall;
         if (cnv_fall)
         begin
            rise_cnt_ff <= 5'h00;
            fall_cnt_ff <= 5'h00;
            converting_ff <= 1'b1;
         end
         else
         begin
            if (data_edge)
            begin
               rise_cnt_ff <= nxt_rise_cnt;
               if (nxt_rise_cnt == `EDGE_LAST)
               begin
                  converting_ff <= 1'b0;
               end
            end
            if (sclk_fall && converting_ff)
            begin
               fall_cnt_ff <= count_up(fall_cnt_ff);
            end
            else if (sclk_fall && fall_cnt_ff != 5'h00)
            begin
               fall_cnt_ff <= count_up(fall_cnt_ff);
            end
         end
      end
   end

   // Serial result output and its drive enable
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         dout_ff <= 1'b0;
         dout_oe_ff <= 1'b0;
         release_pend_ff <= 1'b0;
      end
      else if (cnv_fall)
      begin
         dout_ff <= 1'b0;
         dout_oe_ff <= 1'b1;
         release_pend_ff <= 1'b0;
      end
      else
      begin
         if (data_edge)
         begin
            if (sar_step)
            begin
               // Bit decided on this edge goes straight out
               if (nxt_rise_cnt == `EDGE_MSB)
               begin
                  dout_ff <= comp_high ^ bipolar_sel;
               end
               else
               begin
                  dout_ff <= comp_high;
               end
            end
            else
            begin
               dout_ff <= 1'b0;
            end
         end
         if (sclk_fall && !convert_start_line && fall_cnt_ff == `EDGE_LAST - 5'h01)
         begin
            release_pend_ff <= 1'b1;
         end
         if (cnv_rise)
         begin
            if (release_pend_ff)
            begin
               dout_oe_ff <= 1'b0;
               release_pend_ff <= 1'b0;
            end
            else if (converting_ff && in_window(rise_cnt_ff, `EDGE_PD_MIN, `EDGE_TRACK))
            begin
               dout_oe_ff <= 1'b0;
            end
         end
      end
   end

   // Track-hold control
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         tracking_ff <= 1'b1;
      end
      else if (cnv_fall)
      begin
         tracking_ff <= 1'b0;
      end
      else if (data_edge && nxt_rise_cnt == `EDGE_TRACK)
      begin
         tracking_ff <= 1'b1;
      end
   end

   // Result word and calibration status
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         calib_done_ff <= 1'b0;
         result_word_ff <= 12'h000;
         result_valid_ff <= 1'b0;
      end
      else
      begin
         result_valid_ff <= 1'b0;
         if (data_edge && nxt_rise_cnt == `EDGE_LAST)
         begin
            calib_done_ff <= 1'b1;
            result_valid_ff <= calib_done_ff;
            result_word_ff <= {sar_result[11] ^ bipolar_sel, sar_result[10:0]};
         end
      end
   end

   // Power-down sequencing on the convert-start rise
   always @*
   begin
      nxt_power_state = power_state_ff;
      if (cnv_rise && converting_ff && in_window(rise_cnt_ff, `EDGE_PD_MIN, `EDGE_TRACK))
      begin
         case (power_state_ff)
            `PWR_NORMAL: nxt_power_state = `PWR_PARTIAL;
            `PWR_PARTIAL: nxt_power_state = `PWR_FULL;
            `PWR_FULL: nxt_power_state = `PWR_FULL;
            default: nxt_power_state = `PWR_NORMAL;
         endcase
      end
      else if (cnv_rise && rise_cnt_ff >= `EDGE_TRACK)
      begin
         nxt_power_state = `PWR_NORMAL;
      end
   end

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         power_state_ff <= `PWR_NORMAL;
         ref_enable_ff <= 1'b1;
      end
      else
      begin
         power_state_ff <= nxt_power_state;
         ref_enable_ff <= (nxt_power_state != `PWR_FULL);
      end
   end
endmodule // sar_adc_serial_conversion_port
`default_nettype wire

// File: verif/sar_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sar_port_checker
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic convert_start_line,
   input wire logic dout_ff,
   input wire logic dout_oe_ff,
   input wire logic tracking_ff,
   input wire logic converting_ff,
   input wire logic [1:0] power_state_ff,
   input wire logic result_valid_ff
);
   logic [4:0] cnt_ff;
   logic sq_ff;
   logic cq_ff;
   // Serial clock rises since the last convert-start fall
   always_ff @(posedge clk_sys)
   begin
      sq_ff <= sclk;
      cq_ff <= rst | convert_start_line;
      if (rst || (cq_ff && !convert_start_line))
         cnt_ff <= 5'h00;
      else if (sclk && !sq_ff && cnt_ff != 5'h1f)
         cnt_ff <= cnt_ff + 5'h01;
   end
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   AST_RST_TRACK: assert property (disable iff (1'b0) rst |=> tracking_ff && !dout_oe_ff)
      else $error("reset state");
   AST_START: assert property (
      $fell(convert_start_line) && !converting_ff |-> ##[1:2] (dout_oe_ff && !tracking_ff))
      else $error("start");
   // A convert-start fall may also pull the output low, even after a cut frame left a one on it
   AST_DOUT_SCLK: assert property (
      $changed(dout_ff) |-> (($past(sclk) && (!$past(sclk, 2) || !$past(sclk, 3)))
         || ($past(convert_start_line, 2) && !$past(convert_start_line))))
      else $error("dout edge");
   AST_TRACK_14: assert property ($rose(tracking_ff) && converting_ff |-> cnt_ff == 5'd14)
      else $error("track");
   AST_LEAD_ZERO: assert property (converting_ff && cnt_ff <= 5'd3 |-> !dout_ff)
      else $error("lead");
   AST_TAIL_ZERO: assert property ($past(cnt_ff, 2) >= 5'd16 |-> !dout_ff)
      else $error("tail");
   AST_VALID: assert property (result_valid_ff |-> cnt_ff == 5'd16 ##1 !result_valid_ff)
      else $error("valid");
   AST_OE_HOLD: assert property (dout_oe_ff && !convert_start_line |=> dout_oe_ff)
      else $error("oe hold");
   AST_PWR: assert property (
      $changed(power_state_ff) |-> (power_state_ff == 2'h0 ? cnt_ff >= 5'h0e : cnt_ff inside {[5'h03:5'h0d]}))
      else $error("power");
endmodule // sar_port_checker
bind sar_adc_serial_conversion_port sar_port_checker watch
(
   .clk_sys(clk_sys),
   .rst(rst),
   .sclk(sclk),
   .convert_start_line(convert_start_line),
   .dout_ff(dout_ff),
   .dout_oe_ff(dout_oe_ff),
   .tracking_ff(tracking_ff),
   .converting_ff(converting_ff),
   .power_state_ff(power_state_ff),
   .result_valid_ff(result_valid_ff)
);
`default_nettype wire

// File: verif/host_serial_master.sv
`timescale 1ns/1ns
`default_nettype none
module host_serial_master
(
   input wire logic clk_sys,
   input wire logic dout_pin,
   output var logic sclk,
   output var logic convert_start_line,
   output var logic [15:0] word
);
   initial
   begin
      sclk = 1'b0;
      convert_start_line = 1'b1;
   end
   // Clock stands still outside frames; a rise before clock 14 ends the frame
   task automatic frame(input int rise_at, input int half);
      @(posedge clk_sys);
      convert_start_line <= 1'b0;
      for (int i = 1; i <= (rise_at < 14 ? rise_at : 16); i++)
      begin
         repeat (half) @(posedge clk_sys);
         word = {word[14:0], dout_pin};
         sclk <= 1'b1;
         repeat (half) @(posedge clk_sys);
         sclk <= 1'b0;
         if (i == rise_at)
            convert_start_line <= 1'b1;
      end
      repeat (half) @(posedge clk_sys);
      word = {word[14:0], dout_pin};
      convert_start_line <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule // host_serial_master
`default_nettype wire

// File: verif/tb_sar_adc_serial_conversion_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sar_adc_serial_conversion_port;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic comp_high = 1'b0;
   logic bipolar_sel = 1'b0;
   logic [11:0] vin = 12'h000;
   logic sclk, convert_start_line, dout_ff, dout_oe_ff, tracking_ff, converting_ff;
   logic calib_done_ff, ref_enable_ff, result_valid_ff;
   logic [1:0] power_state_ff;
   logic [11:0] result_word_ff, dac_code;
   logic [15:0] word;
   wire logic dout_pin;
   int mismatches = 0;
   int total_checks = 0;
   int nvalid = 0;
   int cyc = 0;
   always #25 clk_sys = ~clk_sys;
   assign dout_pin = dout_oe_ff ? dout_ff : 1'bz;
   sar_adc_serial_conversion_port dut
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .sclk(sclk),
      .convert_start_line(convert_start_line),
      .comp_high(comp_high),
      .bipolar_sel(bipolar_sel),
      .dout_ff(dout_ff),
      .dout_oe_ff(dout_oe_ff),
      .tracking_ff(tracking_ff),
      .converting_ff(converting_ff),
      .calib_done_ff(calib_done_ff),
      .ref_enable_ff(ref_enable_ff),
      .power_state_ff(power_state_ff),
      .result_word_ff(result_word_ff),
      .result_valid_ff(result_valid_ff),
      .dac_code(dac_code)
   );
   host_serial_master host
   (
      .clk_sys(clk_sys),
      .dout_pin(dout_pin),
      .sclk(sclk),
      .convert_start_line(convert_start_line),
      .word(word)
   );
   // Ideal comparator: input at or above the trial code
   always @(posedge clk_sys)
   begin
      comp_high <= vin >= dac_code;
      cyc <= cyc + 1;
      if (result_valid_ff === 1'b1)
         nvalid <= nvalid + 1;
      if (cyc == 20000)
      begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conv(input logic [11:0] v, input logic b, input int ra);
      int ev;
      int nv;
      vin <= v;
      bipolar_sel <= b;
      nv = nvalid;
      host.frame(ra, 2 + $urandom % 2);
      ev = (v ^ (b << 11)) << 1;
      chk("frame", word, 16'(ev));
      chk("oe", 16'(dout_oe_ff), 16'(ra == 15));
      chk("tracking", 16'(tracking_ff), 16'h0001);
      chk("valid", 16'(nvalid - nv), 16'h0001);
      chk("result", 16'(result_word_ff), 16'(ev >> 1));
   endtask
   initial
   begin
      void'($urandom(32'h4790b64a));
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk("tracking", 16'(tracking_ff), 16'h0001);
      host.frame(17, 2);
      chk("calib", 16'(calib_done_ff), 16'h0001);
      chk("dummy", 16'(nvalid), 16'h0000);
      repeat (6) conv(12'($urandom), 1'($urandom), 17);
      conv(12'hfff, 1'b1, 17);
      conv(12'h000, 1'b0, 17);
      conv(12'($urandom), 1'b0, 15);
      conv(12'($urandom), 1'b1, 17);
      host.frame(3, 2);
      chk("power", 16'(power_state_ff), 16'h0001);
      chk("oe", 16'(dout_oe_ff), 16'h0000);
      host.frame(13, 3);
      chk("power", 16'(power_state_ff), 16'h0002);
      chk("ref", 16'(ref_enable_ff), 16'h0000);
      conv(12'($urandom), 1'b0, 17);
      chk("power", 16'(power_state_ff), 16'h0000);
      chk("ref", 16'(ref_enable_ff), 16'h0001);
      give_verdict();
   end
endmodule // tb_sar_adc_serial_conversion_port
`default_nettype wire
